// [gpl_defines.svh]
// Register offsets, field positions and reset values for the pin configuration block
`ifndef GPL_DEFINES_SVH
`define GPL_DEFINES_SVH

// Register byte addresses
`define GPL_CFG_ADDR 8'h88
`define GPL_IRQ_STATUS_ADDR 8'hA8
`define GPL_IRQ_ENABLE_ADDR 8'hAC

// Configuration field positions
`define GPL_LED_LSB 28
`define GPL_POL_LSB 24
`define GPL_EEF_LSB 20
`define GPL_BUF_LSB 16
`define GPL_DIR_LSB 8
`define GPL_GPO_LSB 3
`define GPL_DATA_LSB 0

// Writable bit mask of the configuration word
`define GPL_CFG_WMASK 32'h7777_071F
`define GPL_CFG_RESET 32'h0000_0000

// Input glitch time and its cycle count at 50 ns per cycle, rounded up
`define GPL_MIN_ACTIVE_NS 40
`define GPL_CLK_PERIOD_NS 50
`define GPL_MIN_ACTIVE_CYC ((`GPL_MIN_ACTIVE_NS + `GPL_CLK_PERIOD_NS - 1) / `GPL_CLK_PERIOD_NS)

// EEPROM pin function encodings
`define GPL_EEF_EEPROM 3'h0
`define GPL_EEF_GPO34 3'h1
`define GPL_EEF_GENERAL_OUTPUT_THREE_RXDV 3'h3
`define GPL_EEF_TXEN_GENERAL_OUTPUT_FOUR 3'h5
`define GPL_EEF_TXEN_RXDV 3'h6
`define GPL_EEF_CLKS 3'h7

`endif

// [gpl_pin_config.sv]
// Pin function, direction, data and pin-level interrupt logic behind an AHB-Lite slave
//
// What this block does
// RULE1: LED enable bit routes pin to LED
// RULE2: Polarity bit picks active input level
// RULE3: Status reaches interrupt only when enabled
// RULE4: Host holds input active over 40 ns
// RULE5: Function field selects EEPROM pin roles
// RULE6: Host avoids reserved codes, mid-cycle changes
// RULE7: Buffer bit set push-pull, clear open-drain
// RULE8: Direction bit set makes pin output
// RULE9: Output bits drive general outputs three, four
// RULE10: Output pin driven with written data bit
// RULE11: Data read returns live pin level
// RULE12: Inputs pass two flip-flops before use
// RULE13: Reserved bits read zero, writes ignored
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "gpl_defines.svh"

module gpl_pin_config (
    input wire logic mclk, // System clock, 20 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic [2:0] pin_in, // General pin input levels
    output gpl_pkg::gpl_pin_drive_t pin_drive, // General pin output and enable
    input wire logic [2:0] led_in, // LED drive from the link logic
    output logic [2:0] led_active, // High where a pin carries its LED
    input wire logic eeprom_data_out, // Data from EEPROM controller
    input wire logic eeprom_data_oe, // Enable from EEPROM controller
    input wire logic eeprom_clock_out, // Clock from EEPROM controller
    input wire logic eeprom_data_in, // Level seen on the data pin
    input wire logic tx_en_in, // MII transmit enable
    input wire logic rx_dv_in, // MII receive valid
    input wire logic tx_clk_in, // MII transmit clock
    input wire logic rx_clk_in, // MII receive clock
    output logic eeprom_data_pin_out, // Data pin output value
    output logic eeprom_data_pin_oe, // Data pin output enable
    output logic eeprom_clock_pin_out, // Clock pin output value
    output logic eeprom_data_rx, // Data pin level back to EEPROM controller
    output logic irq // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus state

    gpl_pkg::gpl_cfg_t cfg; // Configuration fields
    gpl_pkg::gpl_phase_t phase; // Data-phase kind
    logic [7:0] ph_addr; // Latched address
    logic [2:0] sync1; // First synchroniser stage
    logic [2:0] sync2; // Second synchroniser stage
    logic [1:0] sync_fill; // Ones once both stages hold samples; reset zeros would look active
    logic [2:0] irq_status; // Sticky pin events
    logic [2:0] irq_enable; // Per-pin enables
    logic [31:0] cfg_word; // Packed readback of configuration
    logic [31:0] next_rdata; // Read mux
    logic [2:0] pin_event; // Level match per pin
    logic addr_ok; // Address phase accepted
    logic status_read; // Status read taken this cycle
    logic [31:0] wval; // Masked write value
    gpl_pkg::gpl_pin_drive_t next_drive; // Pin drive before the flop
    logic next_edo; // Data pin value
    logic next_edoe; // Data pin enable
    logic next_eco; // Clock pin value

    assign addr_ok = hsel && htrans[1] && hready;
    assign status_read = addr_ok && !hwrite && ({haddr[7:2], 2'b00} == `GPL_IRQ_STATUS_ADDR);
    assign wval = hwdata & `GPL_CFG_WMASK; // [RULE13]

    ////////////////////////////////////////////////////////////////////////////
    // Bus phase capture; every access completes with no wait

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= gpl_pkg::GPL_PH_IDLE;
            ph_addr <= 8'h00;
        end
        else if (addr_ok)
        begin
            // Word aligned only; low address bits are ignored
            phase <= hwrite ? gpl_pkg::GPL_PH_WRITE : gpl_pkg::GPL_PH_READ;
            ph_addr <= {haddr[7:2], 2'b00};
        end
        else if (hready)
        begin
            phase <= gpl_pkg::GPL_PH_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register writes

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg <= gpl_pkg::gpl_cfg_t'(20'h0_0000);
        end
        else if (phase == gpl_pkg::GPL_PH_WRITE && ph_addr == `GPL_CFG_ADDR)
        begin
            cfg.led_route_enable <= wval[`GPL_LED_LSB +: 3]; // [RULE1]
            cfg.pin_irq_polarity <= wval[`GPL_POL_LSB +: 3]; // [RULE2]
            cfg.eeprom_pin_function <= wval[`GPL_EEF_LSB +: 3]; // [RULE5]
            cfg.pin_buffer_type <= wval[`GPL_BUF_LSB +: 3]; // [RULE7]
            cfg.pin_direction <= wval[`GPL_DIR_LSB +: 3]; // [RULE8]
            cfg.general_output_data <= wval[`GPL_GPO_LSB +: 2]; // [RULE9]
            cfg.pin_data <= wval[`GPL_DATA_LSB +: 3]; // [RULE10]
        end
    end

    // Interrupt enable register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable <= 3'h0;
        end
        else if (phase == gpl_pkg::GPL_PH_WRITE && ph_addr == `GPL_IRQ_ENABLE_ADDR)
        begin
            irq_enable <= hwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser; first stage feeds only the second

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync_fill <= 2'b00;
        end
        else
        begin
            sync1 <= pin_in; // [RULE12]
            sync2 <= sync1; // [RULE12]
            sync_fill <= {sync_fill[0], 1'b1}; // [RULE12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level events; a 40 ns pulse may miss a 50 ns sample, so the host must hold longer

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_event
            // Only general-purpose pins report; LED pins are outputs
            assign pin_event[i] = sync_fill[1] && !cfg.led_route_enable[i]
                && (sync2[i] == cfg.pin_irq_polarity[i]); // [RULE2] [RULE4]
        end
    endgenerate

    // Sticky status and flopped interrupt; cleared as the read samples it, so no set is lost
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= (status_read ? 3'h0 : irq_status) | pin_event;
            irq <= |(((status_read ? 3'h0 : irq_status) | pin_event) & irq_enable); // [RULE3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data; pin data field shows live synchronised levels

    always_comb
    begin
        cfg_word = 32'h0000_0000; // [RULE13]
        cfg_word[`GPL_LED_LSB +: 3] = cfg.led_route_enable;
        cfg_word[`GPL_POL_LSB +: 3] = cfg.pin_irq_polarity;
        cfg_word[`GPL_EEF_LSB +: 3] = cfg.eeprom_pin_function;
        cfg_word[`GPL_BUF_LSB +: 3] = cfg.pin_buffer_type;
        cfg_word[`GPL_DIR_LSB +: 3] = cfg.pin_direction;
        cfg_word[`GPL_GPO_LSB +: 2] = cfg.general_output_data;
        cfg_word[`GPL_DATA_LSB +: 3] = sync2; // [RULE11]
    end

    // Address decode for reads; unmapped reads give zero
    always_comb
    begin
        if (!addr_ok || hwrite)
            next_rdata = 32'h0000_0000;
        else if ({haddr[7:2], 2'b00} == `GPL_CFG_ADDR)
            next_rdata = cfg_word;
        else if ({haddr[7:2], 2'b00} == `GPL_IRQ_STATUS_ADDR)
            next_rdata = {29'h0, irq_status};
        else if ({haddr[7:2], 2'b00} == `GPL_IRQ_ENABLE_ADDR)
            next_rdata = {29'h0, irq_enable};
        else
            next_rdata = 32'h0000_0000;
    end

    // Read data captured at the address edge so it stands in the data phase
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            // Zero-wait slave: ready and OKAY always
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready)
                hrdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General pin drive

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (cfg.led_route_enable[i])
            begin
                // LED is active low: sink current when lit, never drive high
                next_drive.out[i] = 1'b0; // [RULE1]
                next_drive.oe[i] = led_in[i]; // [RULE1]
            end
            else if (!cfg.pin_direction[i])
            begin
                next_drive.out[i] = 1'b0; // [RULE8]
                next_drive.oe[i] = 1'b0; // [RULE8]
            end
            else if (cfg.pin_buffer_type[i])
            begin
                next_drive.out[i] = cfg.pin_data[i]; // [RULE10] [RULE7]
                next_drive.oe[i] = 1'b1; // [RULE7]
            end
            else
            begin
                // Open drain: drive only a low
                next_drive.out[i] = 1'b0; // [RULE7]
                next_drive.oe[i] = !cfg.pin_data[i]; // [RULE10] [RULE7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // EEPROM pin role multiplexer; reserved codes leave both pins quiet

    always_comb
    begin
        next_edo = 1'b0;
        next_edoe = 1'b0;
        next_eco = 1'b0;
        case (cfg.eeprom_pin_function) // [RULE5] [RULE6]
            `GPL_EEF_EEPROM:
            begin
                next_edo = eeprom_data_out;
                next_edoe = eeprom_data_oe;
                next_eco = eeprom_clock_out;
            end
            `GPL_EEF_GPO34:
            begin
                next_edo = cfg.general_output_data[0]; // [RULE9]
                next_edoe = 1'b1;
                next_eco = cfg.general_output_data[1]; // [RULE9]
            end
            `GPL_EEF_GENERAL_OUTPUT_THREE_RXDV:
            begin
                next_edo = cfg.general_output_data[0]; // [RULE9]
                next_edoe = 1'b1;
                next_eco = rx_dv_in;
            end
            `GPL_EEF_TXEN_GENERAL_OUTPUT_FOUR:
            begin
                next_edo = tx_en_in;
                next_edoe = 1'b1;
                next_eco = cfg.general_output_data[1]; // [RULE9]
            end
            `GPL_EEF_TXEN_RXDV:
            begin
                next_edo = tx_en_in;
                next_edoe = 1'b1;
                next_eco = rx_dv_in;
            end
            `GPL_EEF_CLKS:
            begin
                next_edo = tx_clk_in;
                next_edoe = 1'b1;
                next_eco = rx_clk_in;
            end
            default: ; // Reserved codes keep the quiet defaults above
        endcase
    end

    // Registered pin outputs
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_drive <= '0;
            led_active <= 3'h0;
            eeprom_data_pin_out <= 1'b0;
            eeprom_data_pin_oe <= 1'b0;
            eeprom_clock_pin_out <= 1'b0;
            eeprom_data_rx <= 1'b0;
        end
        else
        begin
            pin_drive <= next_drive;
            led_active <= cfg.led_route_enable;
            eeprom_data_pin_out <= next_edo;
            eeprom_data_pin_oe <= next_edoe;
            eeprom_clock_pin_out <= next_eco;
            eeprom_data_rx <= eeprom_data_in;
        end
    end

endmodule

// [gpl_pin_config_props.sv]
// Port-level checks for the pin configuration block
`timescale 1ns/1ps
`include "gpl_defines.svh"
module gpl_pin_config_props (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire logic hsel, // Select
    input wire logic [7:0] haddr, // Address
    input wire logic [1:0] htrans, // Type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic [2:0] pin_in, // Pin levels
    input wire gpl_pkg::gpl_pin_drive_t pin_drive, // Pin drive
    input wire logic [2:0] led_in, // LED request
    input wire logic [2:0] led_active, // LED routed
    input wire logic eeprom_data_out, // EEPROM data
    input wire logic eeprom_data_oe, // EEPROM enable
    input wire logic eeprom_clock_out, // EEPROM clock
    input wire logic tx_en_in, // MII
    input wire logic rx_dv_in, // MII
    input wire logic tx_clk_in, // MII
    input wire logic rx_clk_in, // MII
    input wire logic eeprom_data_pin_out, // Data pin
    input wire logic eeprom_data_pin_oe, // Data pin enable
    input wire logic eeprom_clock_pin_out, // Clock pin
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    logic aw, ar, ae; // Pending data phases
    logic [31:0] sh; // Shadow config word
    logic [2:0] sen, lq, pq, xm, pm, xe, pe; // Mask, LED, pins, defined outs, EEPROM pins
    logic [3:0] stab; // Cycles pin levels held
    gpl_pkg::gpl_pin_drive_t xd, pd; // Expected pin drive
    wire take = hsel && htrans[1] && hready;
    // Registers as software wrote them
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {aw, ar, ae, sh, sen} <= '0;
        else
        begin
            aw <= take && hwrite && haddr == `GPL_CFG_ADDR;
            ar <= take && !hwrite && haddr == `GPL_CFG_ADDR;
            ae <= take && hwrite && haddr == `GPL_IRQ_ENABLE_ADDR;
            if (aw)
                sh <= hwdata & `GPL_CFG_WMASK;
            if (ae)
                sen <= hwdata[2:0];
        end
    // Outputs are registered, so expectations lag one edge
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {lq, pm, pe, pd, pq, stab} <= '0;
        else
        begin
            lq <= sh[30:28];
            pm <= xm;
            pe <= xe;
            pd <= xd;
            pq <= pin_in;
            stab <= (pin_in != pq) ? 4'h0 : stab + {3'h0, stab != 4'hF};
        end
    // LED wins, then direction and buffer type
    always_comb
    begin
        xm = sh[30:28] | sh[10:8];
        for (int i = 0; i < 3; i++)
        begin
            xd.out[i] = !sh[28+i] && sh[8+i] && sh[16+i] && sh[i];
            xd.oe[i] = sh[28+i] ? led_in[i] : sh[8+i] && (sh[16+i] || !sh[i]);
        end
        case (sh[22:20])
            3'h0: xe = {eeprom_data_out, eeprom_clock_out, eeprom_data_oe};
            3'h1: xe = {sh[3], sh[4], 1'b1};
            3'h3: xe = {sh[3], rx_dv_in, 1'b1};
            3'h5: xe = {tx_en_in, sh[4], 1'b1};
            3'h6: xe = {tx_en_in, rx_dv_in, 1'b1};
            3'h7: xe = {tx_clk_in, rx_clk_in, 1'b1};
            default: xe = 3'h0;
        endcase
    end
    chk_led_route: assert property (led_active == lq)
        else $error("LED routing wrong");
    chk_pin_oe: assert property (pin_drive.oe == pd.oe)
        else $error("pin enable wrong");
    chk_pin_out: assert property (((pin_drive.out ^ pd.out) & pm) == 3'h0)
        else $error("pin output wrong");
    chk_eep_map: assert property (
        {eeprom_data_pin_out, eeprom_clock_pin_out, eeprom_data_pin_oe} == pe)
        else $error("EEPROM pin role wrong");
    chk_irq_quiet: assert property (sen == 3'h0 |=> !irq)
        else $error("interrupt while masked");
    chk_read_cfg: assert property (ar |-> hrdata[31:3] == sh[31:3])
        else $error("config read wrong");
    chk_pin_read: assert property (ar && stab > 4'h4 |-> hrdata[2:0] == pin_in)
        else $error("pin level read wrong");
    for (genvar i = 0; i < 3; i++)
    begin : g_irq
        chk_irq_set: assert property (
            (sen[i] && !sh[28+i] && !sh[8+i] && pin_in[i] == sh[24+i]) [*3] |=> irq)
            else $error("active pin gave no interrupt");
    end
endmodule
bind gpl_pin_config gpl_pin_config_props u_props (.mclk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .pin_in, .pin_drive, .led_in, .led_active,
    .eeprom_data_out, .eeprom_data_oe, .eeprom_clock_out, .tx_en_in, .rx_dv_in, .tx_clk_in,
    .rx_clk_in, .eeprom_data_pin_out, .eeprom_data_pin_oe, .eeprom_clock_pin_out, .irq);

// [gpl_pin_world.sv]
// Outside world of the pins: pull-ups and an outside driver
`timescale 1ns/1ps
module gpl_pin_world (
    input wire gpl_pkg::gpl_pin_drive_t pin_drive, // Block pin drive
    input wire logic [2:0] ext_en, // Outside driver on
    input wire logic [2:0] ext_val, // Outside driver level
    input wire logic ee_out, // Data pin value
    input wire logic ee_oe, // Data pin enable
    output logic [2:0] pin_level, // Resolved pin levels
    output logic ee_level // Resolved data pin
);
    // Undriven lines float up, so an open-drain high reads one
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            pin_level[i] = pin_drive.oe[i] ? pin_drive.out[i] : (!ext_en[i] || ext_val[i]);
        ee_level = !ee_oe || ee_out;
    end
endmodule

// [gpl_pkg.sv]
// Types shared by the pin configuration block
package gpl_pkg;

    // Configuration register fields
    typedef struct packed {
        logic [2:0] led_route_enable;
        logic [2:0] pin_irq_polarity;
        logic [2:0] eeprom_pin_function;
        logic [2:0] pin_buffer_type;
        logic [2:0] pin_direction;
        logic [1:0] general_output_data;
        logic [2:0] pin_data;
    } gpl_cfg_t;

    // Output and enable for the three pins
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } gpl_pin_drive_t;

    // Bus data-phase tracking
    typedef enum logic [1:0] {
        GPL_PH_IDLE,
        GPL_PH_READ,
        GPL_PH_WRITE
    } gpl_phase_t;

endpackage

// [testbench.sv]
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
`include "gpl_defines.svh"
`define CHK(a, b) \
    begin \
        total_checks++; \
        if ((a) !== (b)) \
        begin \
            err_count++; \
            $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
        end \
    end
module testbench;
    typedef struct packed {logic [31:0] cfg, rd; logic [5:0] drv, msk;} gpl_tb_row_t;
    logic mclk = 1'b0; // Clock
    logic rst_n = 1'b0; // Reset
    logic hsel = 1'b0; // Select
    logic [7:0] haddr = 8'h00; // Address
    logic [1:0] htrans = 2'h0; // Type
    logic hwrite = 1'b0; // Write
    logic [31:0] hwdata = 32'h0000_0000; // Write data
    logic [31:0] hrdata, rd; // Read data, last read
    logic [6:0] sig = 7'h00; // EEPROM controller and MII inputs
    logic [2:0] ext_en = 3'h0; // Outside driver on
    logic [2:0] pin_in, led_active; // Pins, LED routing
    logic hreadyout, hresp, ee_out, ee_oe, ee_clk, ee_in, ee_rx, irq; // Outputs
    gpl_pkg::gpl_pin_drive_t pin_drive; // Pin drive
    int err_count = 0; // Mismatches
    int total_checks = 0; // Comparisons
    int cyc = 0; // Cycles run
    // Config, read back, pin drive {out, oe} and its mask
    gpl_tb_row_t rows [5] = '{'{32'h0007_0707, 32'h0007_0707, 6'h3F, 6'h3F},
        '{32'h0000_0705, 32'h0000_0705, 6'h02, 6'h3F},
        '{32'h0000_0002, 32'h0000_0007, 6'h00, 6'h07},
        '{32'h1007_0707, 32'h1007_0706, 6'h37, 6'h3F},
        '{32'hFFFF_FFFF, 32'h7777_071A, 6'h05, 6'h3F}};
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7}; // Legal only
    ////////////////////////////////////////
    gpl_pin_config uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_drive(pin_drive), .led_in(3'h5), .led_active(led_active),
        .eeprom_data_out(sig[6]), .eeprom_data_oe(sig[0]), .eeprom_clock_out(sig[5]),
        .eeprom_data_in(ee_in), .tx_en_in(sig[4]), .rx_dv_in(sig[3]), .tx_clk_in(sig[2]),
        .rx_clk_in(sig[1]), .eeprom_data_pin_out(ee_out), .eeprom_data_pin_oe(ee_oe),
        .eeprom_clock_pin_out(ee_clk), .eeprom_data_rx(ee_rx), .irq(irq));
    gpl_pin_world env (.pin_drive(pin_drive), .ext_en(ext_en), .ext_val(3'h0),
        .ee_out(ee_out), .ee_oe(ee_oe), .pin_level(pin_in), .ee_level(ee_in));
    always #25 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task end_of_test;
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Single word transfer, then one idle cycle
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w,
        output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
        @(posedge mclk);
    endtask
    // Pull a pin low from outside for three cycles
    task automatic pulse(input logic [2:0] m);
        ext_en <= m;
        repeat (3) @(posedge mclk); // Longer than 40 ns
        ext_en <= 3'h0;
        repeat (5) @(posedge mclk);
    endtask
    // Data pin, clock pin, data enable for a function code
    function automatic logic [2:0] eep_exp(input logic [2:0] f, input logic [1:0] g);
        case (f)
            3'h0: return {sig[6], sig[5], sig[0]};
            3'h1: return {g[0], g[1], 1'b1};
            3'h3: return {g[0], sig[3], 1'b1};
            3'h5: return {sig[4], g[1], 1'b1};
            3'h6: return {sig[4], sig[3], 1'b1};
            default: return {sig[2], sig[1], 1'b1};
        endcase
    endfunction
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[k])
        begin
            bus(`GPL_CFG_ADDR, rows[k].cfg, 1'b1, rd);
            repeat (4) @(posedge mclk);
            `CHK(6'(pin_drive) & rows[k].msk, rows[k].drv)
            `CHK(led_active, rows[k].cfg[30:28])
            `CHK({hresp, hreadyout}, 2'b01)
            bus(`GPL_CFG_ADDR, 32'h0000_0000, 1'b0, rd);
            `CHK(rd, rows[k].rd)
        end
        for (int p = 0; p < 2; p++)
        begin
            sig <= p[0] ? 7'h32 : 7'h4D;
            foreach (codes[k])
            begin
                bus(`GPL_CFG_ADDR, {9'h000, codes[k], 15'h0000, p[0], !p[0], 3'h0}, 1'b1, rd);
                repeat (2) @(posedge mclk);
                `CHK({ee_out, ee_clk, ee_oe}, eep_exp(codes[k], {p[0], !p[0]}))
                `CHK(ee_rx, ee_in)
            end
        end
        bus(`GPL_CFG_ADDR, 32'h0000_0000, 1'b1, rd);
        // Clear events that earlier low pins left behind
        bus(`GPL_IRQ_STATUS_ADDR, 32'h0000_0000, 1'b0, rd);
        bus(`GPL_IRQ_ENABLE_ADDR, 32'h0000_0001, 1'b1, rd);
        pulse(3'h1);
        `CHK(irq, 1'b1)
        bus(`GPL_IRQ_STATUS_ADDR, 32'h0000_0000, 1'b0, rd);
        `CHK(rd, 32'h0000_0001)
        @(posedge mclk);
        `CHK(irq, 1'b0)
        bus(`GPL_IRQ_ENABLE_ADDR, 32'h0000_0000, 1'b1, rd);
        pulse(3'h1);
        `CHK(irq, 1'b0)
        bus(`GPL_IRQ_ENABLE_ADDR, 32'h0000_0001, 1'b1, rd);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        bus(`GPL_IRQ_STATUS_ADDR, 32'h0000_0000, 1'b0, rd);
        bus(`GPL_IRQ_ENABLE_ADDR, 32'h0000_0002, 1'b1, rd);
        bus(`GPL_CFG_ADDR, 32'h0200_0000, 1'b1, rd);
        repeat (4) @(posedge mclk);
        `CHK(irq, 1'b1)
        bus(`GPL_IRQ_ENABLE_ADDR, 32'h0000_0000, 1'b1, rd);
        bus(8'h40, 32'hFFFF_FFFF, 1'b1, rd);
        bus(8'h40, 32'h0000_0000, 1'b0, rd);
        `CHK(rd, 32'h0000_0000)
        bus(`GPL_CFG_ADDR, 32'h0000_0000, 1'b0, rd);
        `CHK(rd, 32'h0200_0007)
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk); // Pin levels refill the synchroniser
        bus(`GPL_CFG_ADDR, 32'h0000_0000, 1'b0, rd);
        `CHK(rd, 32'h0000_0007)
        end_of_test();
    end
endmodule
